// file: design/tdc_regs_pkg.sv
// Register map, reset values and field helpers for the converter slice.
// Assumes a single clock domain; pins are synchronised before use.
package tdc_regs_pkg;
    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [5:0] ADDR_OVF_HI  = 6'h06;
    localparam logic [5:0] ADDR_OVF_LO  = 6'h07;
    localparam logic [5:0] ADDR_GATE_HI = 6'h08;
    localparam logic [5:0] ADDR_GATE_LO = 6'h09;
    localparam logic [5:0] ADDR_INT1    = 6'h10;
    localparam logic [5:0] ADDR_CNT1    = 6'h11;
    localparam logic [5:0] ADDR_INT2    = 6'h12;
    localparam logic [5:0] ADDR_CNT2    = 6'h13;
    // ************************************************
    // Reset values and layout
    // ************************************************
    localparam logic [7:0]  OVF_RST    = 8'hFF;
    localparam logic [7:0]  GATE_RST   = 8'h00;
    localparam logic [23:0] RES_RST    = 24'h000000;
    localparam int          PAR_BIT    = 23;
    localparam int          INT_W      = 23;
    localparam int          CNT_W      = 16;
    localparam int          CMD_BITS   = 8;
    localparam int          DATA_BITS  = 8;
    localparam int          CMD_WR_BIT = 6;
    localparam int          REF_DIV_DEF = 8;
    localparam logic [5:0]  BITS_MAX   = 6'h3F;

    // Parity bit makes the data bits plus parity even
    function automatic logic [23:0] pack_interval(input logic [INT_W-1:0] v);
        return {^v, v};
    endfunction : pack_interval

    function automatic logic [23:0] pack_count(input logic [CNT_W-1:0] v);
        return {^v, 7'h00, v};
    endfunction : pack_count

    function automatic logic is_wide(input logic [5:0] a);
        return (a >= ADDR_INT1) && (a <= ADDR_CNT2);
    endfunction : is_wide
endpackage : tdc_regs_pkg

// file: design/reg_access_if.sv
// Register access path between the serial port and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic [5:0]  addr;
    logic        wr;
    logic [7:0]  wdata;
    logic [23:0] rdata;
    modport regs   (input addr, input wr, input wdata, output rdata);
    modport serial (output addr, output wr, output wdata, input rdata);
endinterface : reg_access_if
`default_nettype wire

// file: design/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t s_q;
    sync_t s_d;

    always_comb
    begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign q = s_q.s2;
endmodule : pin_sync
`default_nettype wire

// file: design/serial_port.sv
// Serial register port: command byte, then one write byte or read data.
// Assumes synchronised chip select, clock and data; mode 0, MSB first.
`timescale 1ns/1ps
`default_nettype none
module serial_port
    import tdc_regs_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  cs_n,
    input  wire logic  sclk,
    input  wire logic  sdi,
    output var  logic  sdo,
    output var  logic  sdo_oe_n,
    reg_access_if.serial bus
);
    typedef struct packed {
        logic        sclk_prev;
        logic [5:0]  bits;
        logic [7:0]  sh_in;
        logic [5:0]  addr;
        logic        is_wr;
        logic [23:0] sh_out;
        logic        sdo;
        logic        oe_n;
        logic        wr;
        logic [7:0]  wdata;
    } spi_t;
    localparam spi_t S_RST = '{oe_n: 1'b1, default: '0};
    spi_t s_q;
    spi_t s_d;
    logic rise;
    logic fall;
    logic [7:0] nxt;
    logic [23:0] rd_al;

    assign rise  = sclk & ~s_q.sclk_prev;
    assign fall  = ~sclk & s_q.sclk_prev;
    assign nxt   = {s_q.sh_in[6:0], sdi};
    assign rd_al = is_wide(s_q.addr) ? bus.rdata : {bus.rdata[7:0], 16'h0000};

    always_comb
    begin
        s_d = s_q;
        s_d.wr = 1'b0;
        s_d.sclk_prev = sclk;
        s_d.oe_n = cs_n;
        if (cs_n)
        begin
            // Deselected: frame state dropped, pin released
            s_d.bits = '0;
            s_d.sdo = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                s_d.sh_in = nxt;
                if (s_q.bits != BITS_MAX)
                    s_d.bits = s_q.bits + 6'h01;
                if (s_q.bits == 6'(CMD_BITS - 1))
                begin
                    s_d.is_wr = nxt[CMD_WR_BIT];
                    s_d.addr = nxt[5:0];
                end
                if (s_q.is_wr && s_q.bits == 6'(CMD_BITS + DATA_BITS - 1))
                begin
                    s_d.wr = 1'b1;
                    s_d.wdata = nxt;
                end
            end
            // Read data is loaded on the first falling edge after the command
            if (fall && !s_q.is_wr && s_q.bits >= 6'(CMD_BITS))
            begin
                if (s_q.bits == 6'(CMD_BITS))
                begin
                    s_d.sdo = rd_al[23];
                    s_d.sh_out = {rd_al[22:0], 1'b0};
                end
                else
                begin
                    s_d.sdo = s_q.sh_out[23];
                    s_d.sh_out = {s_q.sh_out[22:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= S_RST;
        else if (ce)
            s_q <= s_d;
    end

    assign sdo       = s_q.sdo;
    assign sdo_oe_n  = s_q.oe_n;
    assign bus.addr  = s_q.addr;
    assign bus.wr    = s_q.wr;
    assign bus.wdata = s_q.wdata;

    // ************************************************
    // Checks
    // ************************************************
    deselect_quiet_a: assert property (@(posedge clk) disable iff (rst)
        ce && cs_n |=> sdo_oe_n && !bus.wr)
        else $error("serial port active while deselected");
    write_cover_c: cover property (@(posedge clk) disable iff (rst) bus.wr);
endmodule : serial_port
`default_nettype wire

// file: design/tdc_slice.sv
// Converter slice top: pins, register bank and the clock-count engine.
// Assumes clk is the measurement reference; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module tdc_slice
    import tdc_regs_pkg::*;
#(
    parameter int REF_DIV = REF_DIV_DEF
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic converter_chip_select_n,
    input  wire logic sclk,
    input  wire logic sdi,
    output var  logic sdo,
    output var  logic sdo_oe_n,
    input  wire logic start_pin,
    input  wire logic stop_pin,
    input  wire logic arm,
    input  wire logic flag_clear,
    output var  logic clock_overflow_status_flag,
    output var  logic meas_busy,
    output var  logic meas_done
);
    localparam int DIV_W = $clog2(REF_DIV + 1);

    typedef enum logic [1:0] {IDLE, ARMED, RUN} phase_t;

    typedef struct packed {
        logic [7:0]       ovf_hi;
        logic [7:0]       ovf_lo;
        logic [7:0]       gate_hi;
        logic [7:0]       gate_lo;
        logic [23:0]      int1;
        logic [23:0]      cnt1;
        logic [23:0]      int2;
        logic [23:0]      cnt2;
        phase_t           phase;
        logic [CNT_W-1:0] count;
        logic [INT_W-1:0] elapsed;
        logic [DIV_W-1:0] div;
        logic             slot;
        logic             start_prev;
        logic             stop_prev;
        logic             ovf_flag;
        logic             done;
    } state_t;

    localparam state_t S_RST = '{
        ovf_hi:  OVF_RST,
        ovf_lo:  OVF_RST,
        gate_hi: GATE_RST,
        gate_lo: GATE_RST,
        int1:    RES_RST,
        cnt1:    RES_RST,
        int2:    RES_RST,
        cnt2:    RES_RST,
        phase:   IDLE,
        default: '0
    };

    state_t s_q;
    state_t s_d;

    // ************************************************
    // Pins and serial port
    // ************************************************
    logic [4:0] pins_s;
    logic       sel_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       start_s;
    logic       stop_s;

    pin_sync #(
        .W (5)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        // Select is synced active high so the cleared flops read as deselected
        .d   ({~converter_chip_select_n, sclk, sdi, start_pin, stop_pin}),
        .q   (pins_s)
    );

    assign {sel_s, sclk_s, sdi_s, start_s, stop_s} = pins_s;

    reg_access_if bus ();

    serial_port u_port (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .cs_n     (~sel_s),
        .sclk     (sclk_s),
        .sdi      (sdi_s),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .bus      (bus.serial)
    );

    // ************************************************
    // Engine helpers
    // ************************************************
    logic [CNT_W-1:0] ovf_limit;
    logic [CNT_W-1:0] stop_gate;
    logic             start_rise;
    logic             stop_rise;
    logic             over;
    logic             capture;

    assign ovf_limit  = {s_q.ovf_hi, s_q.ovf_lo};
    assign stop_gate  = {s_q.gate_hi, s_q.gate_lo};
    assign start_rise = start_s & ~s_q.start_prev;
    assign stop_rise  = stop_s & ~s_q.stop_prev;
    assign over       = (s_q.phase == RUN) && (s_q.count > ovf_limit);
    // Stops before the gate count are simply dropped
    assign capture    = (s_q.phase == RUN) && !over && stop_rise
                        && (s_q.count >= stop_gate);

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.start_prev = start_s;
        s_d.stop_prev = stop_s;
        if (bus.wr)
        begin
            // Result registers and unmapped offsets ignore writes
            case (bus.addr)
                ADDR_OVF_HI:  s_d.ovf_hi = bus.wdata;
                ADDR_OVF_LO:  s_d.ovf_lo = bus.wdata;
                ADDR_GATE_HI: s_d.gate_hi = bus.wdata;
                ADDR_GATE_LO: s_d.gate_lo = bus.wdata;
                default:      ;
            endcase
        end
        // Clear first so a same-cycle overflow still sets the flag
        if (flag_clear)
            s_d.ovf_flag = 1'b0;
        unique case (s_q.phase)
            IDLE:
            begin
                if (arm)
                begin
                    s_d.phase = ARMED;
                    s_d.slot = 1'b0;
                end
            end
            ARMED:
            begin
                if (start_rise)
                begin
                    s_d.phase = RUN;
                    s_d.count = '0;
                    s_d.elapsed = '0;
                    s_d.div = '0;
                end
            end
            RUN:
            begin
                if (over)
                begin
                    // Overflow ends the run in the same cycle
                    s_d.ovf_flag = 1'b1;
                    s_d.phase = IDLE;
                    s_d.done = 1'b1;
                end
                else
                begin
                    // Unsigned cycle count, saturating at full scale
                    if (s_q.elapsed != {INT_W{1'b1}})
                        s_d.elapsed = s_q.elapsed + 1'b1;
                    if (s_q.div == DIV_W'(REF_DIV - 1))
                    begin
                        s_d.div = '0;
                        if (s_q.count != {CNT_W{1'b1}})
                            s_d.count = s_q.count + 1'b1;
                    end
                    else
                        s_d.div = s_q.div + 1'b1;
                    if (capture)
                    begin
                        if (!s_q.slot)
                        begin
                            s_d.int1 = pack_interval(s_q.elapsed);
                            s_d.cnt1 = pack_count(s_q.count);
                            s_d.slot = 1'b1;
                        end
                        else
                        begin
                            s_d.int2 = pack_interval(s_q.elapsed);
                            s_d.cnt2 = pack_count(s_q.count);
                            s_d.phase = IDLE;
                            s_d.done = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= S_RST;
        else if (ce)
            s_q <= s_d;
    end

    // ************************************************
    // Read path
    // ************************************************
    always_comb
    begin
        case (bus.addr)
            ADDR_OVF_HI:  bus.rdata = {16'h0000, s_q.ovf_hi};
            ADDR_OVF_LO:  bus.rdata = {16'h0000, s_q.ovf_lo};
            ADDR_GATE_HI: bus.rdata = {16'h0000, s_q.gate_hi};
            ADDR_GATE_LO: bus.rdata = {16'h0000, s_q.gate_lo};
            ADDR_INT1:    bus.rdata = s_q.int1;
            ADDR_CNT1:    bus.rdata = s_q.cnt1;
            ADDR_INT2:    bus.rdata = s_q.int2;
            ADDR_CNT2:    bus.rdata = s_q.cnt2;
            default:      bus.rdata = '0;
        endcase
    end

    assign clock_overflow_status_flag = s_q.ovf_flag;
    assign meas_busy = (s_q.phase != IDLE);
    assign meas_done = s_q.done;

    // ************************************************
    // Checks
    // ************************************************
    limit_low_write_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == ADDR_OVF_LO |=> s_q.ovf_lo == $past(bus.wdata))
        else $error("overflow limit low byte not written");
    limit_high_write_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == ADDR_OVF_HI |=> s_q.ovf_hi == $past(bus.wdata))
        else $error("overflow limit high byte not written");
    gate_high_write_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == ADDR_GATE_HI |=> s_q.gate_hi == $past(bus.wdata))
        else $error("stop gate high byte not written");
    gate_low_write_a: assert property (@(posedge clk) disable iff (rst)
        ce && bus.wr && bus.addr == ADDR_GATE_LO |=> s_q.gate_lo == $past(bus.wdata))
        else $error("stop gate low byte not written");
    interval_parity_a: assert property (@(posedge clk) disable iff (rst)
        (bus.addr == ADDR_INT1 || bus.addr == ADDR_INT2)
        |-> bus.rdata[PAR_BIT] == ^bus.rdata[INT_W-1:0])
        else $error("interval parity wrong");
    count_reserved_a: assert property (@(posedge clk) disable iff (rst)
        (bus.addr == ADDR_CNT1 || bus.addr == ADDR_CNT2)
        |-> bus.rdata[22:16] == 7'h00 && bus.rdata[PAR_BIT] == ^bus.rdata[CNT_W-1:0])
        else $error("count reserved bits or parity wrong");
    first_capture_a: assert property (@(posedge clk) disable iff (rst)
        ce && capture && !s_q.slot
        |=> s_q.cnt1[CNT_W-1:0] == $past(s_q.count) && s_q.int1[INT_W-1:0] == $past(s_q.elapsed))
        else $error("first result pair not captured");
    second_capture_a: assert property (@(posedge clk) disable iff (rst)
        ce && capture && s_q.slot
        |=> s_q.cnt2[CNT_W-1:0] == $past(s_q.count) && s_q.phase == IDLE && meas_done)
        else $error("second result pair not captured");
    elapsed_step_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.phase == RUN && !over && s_q.elapsed != {INT_W{1'b1}}
        |=> s_q.elapsed == INT_W'($past(s_q.elapsed) + 1'b1))
        else $error("interval count did not step by one");
    overflow_stop_a: assert property (@(posedge clk) disable iff (rst)
        ce && over |=> clock_overflow_status_flag && !meas_busy && meas_done)
        else $error("overflow did not stop the run");
    gate_block_a: assert property (@(posedge clk) disable iff (rst)
        ce && s_q.phase == RUN && !over && stop_rise && s_q.count < stop_gate
        |=> $stable(s_q.int1) && $stable(s_q.int2) && $stable(s_q.slot))
        else $error("stop accepted before gate count");
    overflow_cover_c: cover property (@(posedge clk) disable iff (rst) ce && over);
    two_stops_cover_c: cover property (@(posedge clk) disable iff (rst)
        ce && capture && s_q.slot);
    gated_stop_cover_c: cover property (@(posedge clk) disable iff (rst)
        ce && s_q.phase == RUN && stop_rise && s_q.count < stop_gate);
endmodule : tdc_slice
`default_nettype wire

// file: dv/spi_host_model.sv
// Host side of the serial register port: frames of command byte plus data.
// Assumes mode 0, MSB first, and a clk fast enough for a 6-cycle half period.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic clk,
    output var  logic cs_n,
    output var  logic sclk,
    input  wire logic sdo,
    output var  logic sdi
);
    // Half period leaves room for the device's 3-cycle sync and edge detect
    localparam int HALF = 6;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Data is sampled before the rise, long after the device shifted on the fall
    task automatic bit_x(input logic b, output logic s);
        sdi <= b;
        idle(HALF);
        @(negedge clk);
        s = sdo;
        @(posedge clk);
        sclk <= 1'b1;
        idle(HALF);
        sclk <= 1'b0;
    endtask : bit_x

    task automatic frame(input logic sel, input logic [7:0] cmd, input logic [7:0] wd,
                         input int n, output logic [23:0] rd);
        logic s;
        rd = 24'h000000;
        @(posedge clk);
        cs_n <= ~sel;
        for (int i = 7; i >= 0; i--)
            bit_x(cmd[i], s);
        for (int i = 0; i < n; i++)
        begin
            bit_x(cmd[6] ? wd[7-i] : ~sdi, s);
            rd = {rd[22:0], s};
        end
        idle(HALF);
        cs_n <= 1'b1;
        // Released line does not keep its last level
        sdi  <= ~sdi;
        idle(8);
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// file: dv/tdc_slice_tb.sv
// Self-checking bench for the converter slice: register map and measurement.
// Assumes the host model drives the serial pins; ce is held high except during the freeze scenario.
`timescale 1ns/1ps
`default_nettype none
module tdc_slice_tb;
    import tdc_regs_pkg::*;
    localparam int DIV = 2;
    logic        clk;
    logic        rst;
    logic        ce;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe_n;
    logic        start_pin;
    logic        stop_pin;
    logic        arm;
    logic        flag_clear;
    logic        ovf_flag;
    logic        busy;
    logic        done;
    logic [23:0] rd;
    logic        host_sel;
    int          failures;
    int          cmp_count;
    int          done_seen;

    tdc_slice #(.REF_DIV(DIV)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .converter_chip_select_n(cs_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .start_pin(start_pin),
        .stop_pin(stop_pin), .arm(arm), .flag_clear(flag_clear),
        .clock_overflow_status_flag(ovf_flag), .meas_busy(busy), .meas_done(done));
    spi_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdi(sdi));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Done is a single-cycle pulse, so it is counted here rather than polled
    always @(posedge clk)
        if (done === 1'b1)
            done_seen++;

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_host.frame(host_sel, {2'b01, a}, d, 8, rd);
    endtask : wr

    task automatic rd_reg(input logic [5:0] a, input int n);
        i_host.frame(host_sel, {2'b00, a}, 8'h00, n, rd);
    endtask : rd_reg

    task automatic expect_reg(input string nm, input logic [5:0] a, input int n,
                              input logic [23:0] exp);
        rd_reg(a, n);
        check(nm, rd, exp);
        check("oe_n idle", {23'h0, sdo_oe_n}, 24'h000001);
    endtask : expect_reg

    // Rising edge on start (0) or stop (1), eight cycles long in all
    task automatic pin(input logic which);
        if (which)
            stop_pin <= 1'b1;
        else
            start_pin <= 1'b1;
        i_host.idle(4);
        stop_pin  <= 1'b0;
        start_pin <= 1'b0;
        i_host.idle(4);
    endtask : pin

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset_vals;
        logic [5:0] a [8] = '{ADDR_OVF_HI, ADDR_OVF_LO, ADDR_GATE_HI, ADDR_GATE_LO,
                              ADDR_INT1, ADDR_CNT1, ADDR_INT2, ADDR_CNT2};
        check("flag reset", {23'h0, ovf_flag}, 24'h000000);
        for (int i = 0; i < 8; i++)
            expect_reg("reset", a[i], i < 4 ? 8 : 24, i < 2 ? 24'h0000FF : 24'h0);
        expect_reg("unmapped", 6'h0A, 8, 24'h000000);
    endtask : t_reset_vals

    task automatic t_write_back;
        wr(ADDR_OVF_HI, 8'hA5);
        wr(ADDR_OVF_LO, 8'h3C);
        wr(ADDR_GATE_HI, 8'h5A);
        wr(ADDR_GATE_LO, 8'hC3);
        wr(ADDR_INT1, 8'h55);
        wr(6'h0A, 8'h77);
        expect_reg("ovf_hi", ADDR_OVF_HI, 8, 24'h0000A5);
        expect_reg("ovf_lo", ADDR_OVF_LO, 8, 24'h00003C);
        expect_reg("gate_hi", ADDR_GATE_HI, 8, 24'h00005A);
        expect_reg("gate_lo", ADDR_GATE_LO, 8, 24'h0000C3);
        expect_reg("int1 ro", ADDR_INT1, 24, 24'h000000);
        expect_reg("unmapped", 6'h0A, 8, 24'h000000);
    endtask : t_write_back

    task automatic t_deselect;
        host_sel = 1'b0;
        wr(ADDR_GATE_LO, 8'hFF);
        host_sel = 1'b1;
        check("oe_n unselected", {23'h0, sdo_oe_n}, 24'h000001);
        expect_reg("gate_lo kept", ADDR_GATE_LO, 8, 24'h0000C3);
    endtask : t_deselect

    task automatic t_measure;
        logic [23:0] r [4];
        int          base;
        wr(ADDR_OVF_HI, 8'hFF);
        wr(ADDR_OVF_LO, 8'hFF);
        wr(ADDR_GATE_HI, 8'h00);
        wr(ADDR_GATE_LO, 8'h10);
        base = done_seen;
        arm <= 1'b1;
        i_host.idle(1);
        arm <= 1'b0;
        i_host.idle(2);
        check("busy armed", {23'h0, busy}, 24'h000001);
        pin(1'b0);
        i_host.idle(2);
        // Stop at count near 4 falls short of the gate of 16
        pin(1'b1);
        i_host.idle(42);
        pin(1'b1);
        i_host.idle(32);
        pin(1'b1);
        i_host.idle(4);
        check("done once", 24'(done_seen - base), 24'h000001);
        check("idle after", {23'h0, busy}, 24'h000000);
        for (int i = 0; i < 4; i++)
        begin
            rd_reg(ADDR_INT1 + 6'(i), 24);
            r[i] = rd;
        end
        check("int1 range", (r[0][22:0] >= 56 && r[0][22:0] <= 64), 24'h1);
        check("int spacing", r[2][22:0] - r[0][22:0], 24'd40);
        check("cnt1 gate", r[1][15:0] >= 16, 24'h1);
        check("cnt1 rate", (r[1][15:0] + 1 >= r[0][22:0] / DIV) && (r[1][15:0] <= r[0][22:0] / DIV + 1), 24'h1);
        check("cnt spacing", (r[3][15:0] - r[1][15:0] >= 19) && (r[3][15:0] - r[1][15:0] <= 21), 24'h1);
        for (int i = 0; i < 4; i++)
            check("parity", r[i][23], ^r[i][22:0]);
        check("cnt1 spare", r[1][22:16], 24'h0);
        check("cnt2 spare", r[3][22:16], 24'h0);
    endtask : t_measure

    task automatic t_overflow;
        int n;
        int base;
        wr(ADDR_OVF_HI, 8'h00);
        wr(ADDR_OVF_LO, 8'h04);
        base = done_seen;
        arm <= 1'b1;
        i_host.idle(1);
        arm <= 1'b0;
        pin(1'b0);
        n = 0;
        while (ovf_flag !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("ovf wait", 24'(n < 100), 24'h1);
        check("stopped", {23'h0, busy}, 24'h000000);
        i_host.idle(2);
        check("ovf done", 24'(done_seen - base), 24'h000001);
        flag_clear <= 1'b1;
        i_host.idle(1);
        flag_clear <= 1'b0;
        i_host.idle(2);
        check("flag cleared", {23'h0, ovf_flag}, 24'h000000);
    endtask : t_overflow

    // Clock enable low freezes the synchronisers, so a whole frame is lost
    task automatic t_freeze;
        ce <= 1'b0;
        wr(ADDR_OVF_LO, 8'h11);
        check("frozen oe_n", {23'h0, sdo_oe_n}, 24'h000001);
        ce <= 1'b1;
        i_host.idle(4);
        expect_reg("ovf_lo frozen", ADDR_OVF_LO, 8, 24'h000004);
    endtask : t_freeze

    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        rst        = 1'b1;
        ce         = 1'b1;
        start_pin  = 1'b0;
        stop_pin   = 1'b0;
        arm        = 1'b0;
        flag_clear = 1'b0;
        host_sel   = 1'b1;
        failures   = 0;
        cmp_count  = 0;
        done_seen  = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        i_host.idle(4);
        t_reset_vals();
        t_write_back();
        t_deselect();
        t_measure();
        t_overflow();
        t_freeze();
        complete_run();
    end
endmodule : tdc_slice_tb
`default_nettype wire
